// ===== pkg/adc_ctrl_pkg.sv
// Constants shared by the converter control block and its result FIFO
package adc_ctrl_pkg;
   // ----------------------------------------------------------------
   // Word widths
   // ----------------------------------------------------------------
   localparam int SETUP_W  = 14;
   localparam int RESULT_W = 16;
   localparam int SHIFT_W  = RESULT_W + SETUP_W;
   localparam int FIFO_DEPTH = 8;

   // ----------------------------------------------------------------
   // Setup word fields
   // ----------------------------------------------------------------
   localparam int UPDATE_BIT    = 13;
   localparam int BW_BIT        = 6;
   localparam int REF_HI        = 5;
   localparam int REF_LO        = 3;
   localparam int SCAN_HI       = 2;
   localparam int SCAN_LO       = 1;
   localparam int READBACK_BIT  = 0;
   localparam logic [SETUP_W-1:0] SETUP_DEFAULT = 14'h3fff;

   // Voltage source codes
   localparam logic [2:0] REF_UNUSED      = 3'h0;
   localparam logic [2:0] REF_INT_4V096   = 3'h1;
   localparam logic [2:0] REF_EXT_TEMP    = 3'h2;
   localparam logic [2:0] REF_EXTBUF_TEMP = 3'h3;
   localparam logic [2:0] REF_EXT         = 3'h6;
   localparam logic [2:0] REF_EXTBUF      = 3'h7;

   // Scan mode codes
   localparam logic [1:0] SCAN_OFF      = 2'h0;
   localparam logic [1:0] SCAN_UPDATE   = 2'h1;
   localparam logic [1:0] SCAN_TEMP     = 2'h2;
   localparam logic [1:0] SCAN_CHANNELS = 2'h3;

   // ----------------------------------------------------------------
   // Serial counts and timing
   // ----------------------------------------------------------------
   localparam logic [4:0] RESULT_EDGES   = 5'h10;
   localparam logic [4:0] READBACK_EDGES = 5'h1e;
   localparam logic [3:0] SETUP_EDGES    = 4'he;
   localparam int CLK_PERIOD_NS       = 10;
   localparam int CONVERSION_TIME_NS  = 1600;
   localparam int CONV_CYCLES_INT =
      (CONVERSION_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] CONV_CYCLES = 12'(CONV_CYCLES_INT);
endpackage

// ===== pkg/stream_if.sv
// Valid/ready word stream between the control block and its FIFO
`timescale 1ns/1ps
interface stream_if;
   logic                 valid;
   logic                 ready;
   logic [15:0]          data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/result_fifo.sv
// Parameterised FIFO holding converter results ahead of the shifter
`timescale 1ns/1ps
module result_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Fill side
   stream_if.snk    fill,
   // Drain side
   stream_if.src    drain
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   assign fill.ready  = (count_q != (AW+1)'(DEPTH));
   assign drain.valid = (count_q != '0);
   assign drain.data  = mem[rd_ptr_q];
   assign push        = fill.valid & fill.ready;
   assign pop         = drain.valid & drain.ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_q] <= fill.data;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= AW'((wr_ptr_q + 1'b1) % DEPTH);
         end
         if (pop) begin
            rd_ptr_q <= AW'((rd_ptr_q + 1'b1) % DEPTH);
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule // result_fifo

// ===== rtl/adc_setup_word_and_readout.sv
// Setup word capture, field decode and serial result readout
//
// Function
// - Bit 6 low selects quarter filter bandwidth
// - Bits 5:3 decode reference and sensor
// - Bits 2:1 decode channel scan mode
// - Bit 0 low appends setup after result
// - Strobe high at end disables busy
// - Partial setup word discarded at end
// - Unread result dropped, oldest queued result (or last one if FIFO empty) reloaded MSB
// - Strobe fall after end drives MSB
// - Each falling clock edge advances one bit
// - Release after 16, or 30 with readback
// - Setup captured MSB first, 14 rising edges
// - Bit 13 gates overwriting stored setup
// - New setup applied at conversion end
// - Data input high loads all ones
`timescale 1ns/1ps
module adc_setup_word_and_readout
   import adc_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic                        REF_CLK,
   input  wire logic                        RST_B,
   // Serial pins
   input  wire logic                        CONVERT_STROBE,
   input  wire logic                        SCK,
   input  wire logic                        DIN,
   output      logic                        SDO,
   output      logic                        SDO_OE,
   // Results from the converter core
   input  wire logic                        RESULT_VALID,
   input  wire logic [adc_ctrl_pkg::RESULT_W-1:0] RESULT_DATA,
   output      logic                        RESULT_READY,
   // Setup in effect and its decode
   output      logic [adc_ctrl_pkg::SETUP_W-1:0]  SETUP_WORD,
   output      logic                        FILTER_QUARTER_BW,
   output      logic                        INT_REF_EN,
   output      logic                        REF_BUF_EN,
   output      logic                        TEMP_SENSOR_EN,
   output      logic                        REF_CODE_UNSUPPORTED,
   output      logic                        SCAN_EN,
   output      logic                        SCAN_UPDATE_EN,
   output      logic                        SCAN_TEMP_EN,
   // Conversion status
   output      logic                        CONVERTING,
   output      logic                        EOC_PULSE,
   output      logic                        BUSY_IND_DISABLE
);
   import adc_ctrl_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detect
   // ----------------------------------------------------------------
   logic [2:0] cnv_sync_q;
   logic [2:0] sck_sync_q;
   logic [1:0] din_sync_q;
   logic       convert_strobe;
   logic       cnv_rise;
   logic       sck_rise;
   logic       sck_fall;
   logic       din;

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         cnv_sync_q <= 3'h0;
         sck_sync_q <= 3'h0;
         din_sync_q <= 2'h0;
      end else begin
         cnv_sync_q <= {cnv_sync_q[1:0], CONVERT_STROBE};
         sck_sync_q <= {sck_sync_q[1:0], SCK};
         din_sync_q <= {din_sync_q[0], DIN};
      end
   end

   assign convert_strobe      = cnv_sync_q[1];
   assign cnv_rise = cnv_sync_q[1] & ~cnv_sync_q[2];
   assign sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
   assign sck_fall = ~sck_sync_q[1] & sck_sync_q[2];
   assign din      = din_sync_q[1];

   // ----------------------------------------------------------------
   // Conversion timing
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_ACQUIRE = 2'b01,
      ST_CONVERT = 2'b10
   } conv_state_e;

   conv_state_e state_q;
   logic [11:0] conv_cnt_q;
   logic        eoc;

   assign eoc = (state_q == ST_CONVERT) && (conv_cnt_q == 12'h001);

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q    <= ST_ACQUIRE;
         conv_cnt_q <= 12'h000;
      end else begin
         case (state_q)
            ST_ACQUIRE: begin
               if (cnv_rise) begin
                  state_q    <= ST_CONVERT;
                  conv_cnt_q <= CONV_CYCLES;
               end
            end
            ST_CONVERT: begin
               // Runs to completion whatever the strobe does
               conv_cnt_q <= conv_cnt_q - 12'h001;
               if (eoc) begin
                  state_q <= ST_ACQUIRE;
               end
            end
            default: begin
               state_q    <= ST_ACQUIRE;
               conv_cnt_q <= 12'h000;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         EOC_PULSE        <= 1'b0;
         CONVERTING       <= 1'b0;
         BUSY_IND_DISABLE <= 1'b1;
      end else begin
         EOC_PULSE  <= eoc;
         CONVERTING <= (state_q == ST_CONVERT) && !eoc;
         if (eoc) begin
            BUSY_IND_DISABLE <= convert_strobe;
         end
      end
   end

   // ----------------------------------------------------------------
   // Setup word capture
   // ----------------------------------------------------------------
   logic [SETUP_W-1:0] rx_q;
   logic [3:0]         rx_cnt_q;
   logic [SETUP_W-1:0] setup_q;

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rx_q     <= '0;
         rx_cnt_q <= 4'h0;
      end else if (eoc) begin
         rx_cnt_q <= 4'h0;
      end else if (sck_rise && !convert_strobe && state_q == ST_ACQUIRE
                   && rx_cnt_q != SETUP_EDGES) begin
         rx_q     <= {rx_q[SETUP_W-2:0], din};
         rx_cnt_q <= rx_cnt_q + 4'h1;
      end
   end

   // Reset value equals the all-ones word a high data input loads
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         setup_q <= SETUP_DEFAULT;
      end else if (eoc && rx_cnt_q == SETUP_EDGES
                   && rx_q[UPDATE_BIT]) begin
         setup_q <= rx_q;
      end
   end

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   logic [2:0] ref_code;
   logic [1:0] scan_code;

   assign ref_code  = setup_q[REF_HI:REF_LO];
   assign scan_code = setup_q[SCAN_HI:SCAN_LO];

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         SETUP_WORD        <= SETUP_DEFAULT;
         FILTER_QUARTER_BW <= 1'b0;
      end else begin
         SETUP_WORD        <= setup_q;
         FILTER_QUARTER_BW <= ~setup_q[BW_BIT];
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         INT_REF_EN           <= 1'b0;
         REF_BUF_EN           <= 1'b1;
         TEMP_SENSOR_EN       <= 1'b0;
         REF_CODE_UNSUPPORTED <= 1'b0;
      end else begin
         INT_REF_EN           <= 1'b0;
         REF_BUF_EN           <= 1'b0;
         TEMP_SENSOR_EN       <= 1'b0;
         REF_CODE_UNSUPPORTED <= 1'b0;
         case (ref_code)
            REF_INT_4V096: begin
               INT_REF_EN <= 1'b1;
               REF_BUF_EN <= 1'b1;
            end
            REF_EXT_TEMP: begin
               TEMP_SENSOR_EN <= 1'b1;
            end
            REF_EXTBUF_TEMP: begin
               REF_BUF_EN     <= 1'b1;
               TEMP_SENSOR_EN <= 1'b1;
            end
            REF_EXT: begin
            end
            REF_EXTBUF: begin
               REF_BUF_EN <= 1'b1;
            end
            REF_UNUSED: begin
            end
            default: begin
               REF_CODE_UNSUPPORTED <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         SCAN_EN        <= 1'b1;
         SCAN_UPDATE_EN <= 1'b0;
         SCAN_TEMP_EN   <= 1'b0;
      end else begin
         case (scan_code)
            SCAN_OFF: begin
               SCAN_EN        <= 1'b0;
               SCAN_UPDATE_EN <= 1'b0;
               SCAN_TEMP_EN   <= 1'b0;
            end
            SCAN_UPDATE: begin
               SCAN_EN        <= 1'b1;
               SCAN_UPDATE_EN <= 1'b1;
               SCAN_TEMP_EN   <= 1'b0;
            end
            SCAN_TEMP: begin
               SCAN_EN        <= 1'b1;
               SCAN_UPDATE_EN <= 1'b0;
               SCAN_TEMP_EN   <= 1'b1;
            end
            default: begin
               SCAN_EN        <= 1'b1;
               SCAN_UPDATE_EN <= 1'b0;
               SCAN_TEMP_EN   <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Result buffering
   // ----------------------------------------------------------------
   stream_if fill_s ();
   stream_if drain_s ();

   assign fill_s.valid  = RESULT_VALID;
   assign fill_s.data   = RESULT_DATA;
   assign RESULT_READY  = fill_s.ready;
   assign drain_s.ready = eoc;

   result_fifo #(
      .WIDTH (RESULT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk   (REF_CLK),
      .rst_b (RST_B),
      .fill  (fill_s),
      .drain (drain_s)
   );

   // ----------------------------------------------------------------
   // Serial readout
   // ----------------------------------------------------------------
   logic [SHIFT_W-1:0]  shift_q;
   logic [RESULT_W-1:0] last_result_q;
   logic [RESULT_W-1:0] new_result;
   logic [4:0]          bit_cnt_q;
   logic [4:0]          bit_limit_q;
   logic                armed_q;

   assign new_result = drain_s.valid ? drain_s.data : last_result_q;

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         shift_q       <= '0;
         last_result_q <= '0;
         bit_cnt_q     <= 5'h00;
         bit_limit_q   <= RESULT_EDGES;
         armed_q       <= 1'b0;
      end else if (eoc) begin
         // Unread bits are lost; reload oldest queued result (last one if FIFO empty) from the top
         shift_q       <= {new_result, setup_q};
         last_result_q <= new_result;
         bit_cnt_q     <= 5'h00;
         bit_limit_q   <= setup_q[READBACK_BIT] ? RESULT_EDGES
                                                : READBACK_EDGES;
         armed_q       <= 1'b1;
      end else if (cnv_rise) begin
         armed_q <= 1'b0;
      end else if (sck_fall && SDO_OE) begin
         shift_q   <= {shift_q[SHIFT_W-2:0], 1'b0};
         bit_cnt_q <= bit_cnt_q + 5'h01;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         SDO    <= 1'b0;
         SDO_OE <= 1'b0;
      end else begin
         SDO    <= (sck_fall && SDO_OE) ? shift_q[SHIFT_W-2]
                                        : shift_q[SHIFT_W-1];
         SDO_OE <= armed_q && !convert_strobe && !eoc && !cnv_rise
                   && !(sck_fall && SDO_OE
                        && bit_cnt_q + 5'h01 == bit_limit_q)
                   && bit_cnt_q != bit_limit_q;
      end
   end
endmodule // adc_setup_word_and_readout

// ===== dv/adc_setup_word_and_readout_properties.sv
// Checker for the converter control block ports
`timescale 1ns/1ps
module adc_setup_word_and_readout_properties
   import adc_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic                               REF_CLK,
   input wire logic                               RST_B,
   // Serial pins
   input wire logic                               CONVERT_STROBE,
   input wire logic                               SCK,
   input wire logic                               SDO,
   input wire logic                               SDO_OE,
   // Setup and status
   input wire logic [adc_ctrl_pkg::SETUP_W-1:0]   SETUP_WORD,
   input wire logic                               FILTER_QUARTER_BW,
   input wire logic                               INT_REF_EN,
   input wire logic                               REF_CODE_UNSUPPORTED,
   input wire logic                               SCAN_EN,
   input wire logic                               CONVERTING,
   input wire logic                               EOC_PULSE,
   input wire logic                               BUSY_IND_DISABLE
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_B);

   a_eoc_single_pulse: assert property (EOC_PULSE |=> !EOC_PULSE)
      else $error("end of conversion pulse longer than one cycle");
   a_eoc_ends_conv: assert property ($fell(CONVERTING) |-> EOC_PULSE)
      else $error("conversion ended without end pulse");
   a_busy_sample: assert property (EOC_PULSE |->
      BUSY_IND_DISABLE == $past(CONVERT_STROBE, 3))
      else $error("busy disable does not follow strobe at end");
   a_setup_at_eoc: assert property ($changed(SETUP_WORD) |-> $past(EOC_PULSE))
      else $error("setup changed away from end of conversion");
   a_setup_gated: assert property ($changed(SETUP_WORD) |-> SETUP_WORD[13])
      else $error("setup overwritten without update bit");
   a_bw_decode: assert property ($stable(SETUP_WORD) [*3] |->
      FILTER_QUARTER_BW == !SETUP_WORD[6])
      else $error("bandwidth decode wrong");
   a_ref_decode: assert property ($stable(SETUP_WORD) [*3] |->
      INT_REF_EN == (SETUP_WORD[5:3] == 3'h1) &&
      REF_CODE_UNSUPPORTED == (SETUP_WORD[5:4] == 2'h2))
      else $error("reference decode wrong");
   a_scan_decode: assert property ($stable(SETUP_WORD) [*3] |->
      SCAN_EN == (SETUP_WORD[2:1] != 2'h0))
      else $error("scan decode wrong");
   a_oe_rise_idle: assert property ($rose(SDO_OE) |->
      !CONVERT_STROBE && !CONVERTING)
      else $error("data output enabled while strobe high");
   a_strobe_release: assert property ($rose(CONVERT_STROBE) |->
      ##[1:6] !SDO_OE)
      else $error("data output not released on strobe rise");
   a_sdo_on_fall: assert property (SDO_OE && $past(SDO_OE) && $changed(SDO)
      |-> !$past(SCK))
      else $error("data output moved while serial clock high");
endmodule // adc_setup_word_and_readout_properties

// ===== dv/host_ctrl_model.sv
// Host controller model driving strobe, serial clock and data
`timescale 1ns/1ps
module host_ctrl_model (
   // Serial pins
   output logic      strobe,
   output logic      sck,
   output logic      din,
   input  wire logic sdo,
   input  wire logic sdo_oe
);
   initial begin
      strobe = 1'b0;
      sck    = 1'b0;
      din    = 1'b0;
   end

   // Strobe held high through the end, or dropped early when hold is 0
   task automatic convert(input bit hold);
      strobe = 1'b1;
      #(hold ? 2000 : 100);
      strobe = 1'b0;
      #(hold ? 200 : 2300);
   endtask

   // One frame of n clocks; setup out MSB first, data taken at rise
   task automatic frame(input logic [13:0] w, input int n,
                        output logic [29:0] rd);
      rd = 'x;
      for (int i = 0; i < n; i++) begin
         din = (i < 14) ? w[13-i] : ~din;
         #62.5 sck = 1'b1;
         rd[29-i] = sdo_oe ? sdo : 1'bx;
         #62.5 sck = 1'b0;
      end
      din = ~din;
      #300;
   endtask
endmodule // host_ctrl_model

// ===== dv/adc_setup_word_and_readout_test.sv
// Testbench for setup capture, decode and result readout
`timescale 1ns/1ps
module adc_setup_word_and_readout_test;
   import adc_ctrl_pkg::*;
   logic                ref_clk, rst_b, convert_strobe, sck, din, sdo, sdo_oe;
   logic                res_valid, res_ready, fq, int_ref, ref_buf, temp_en;
   logic                unsup, scan_en, scan_upd, scan_temp;
   logic                converting, eoc, busy_dis;
   logic [RESULT_W-1:0] res_data;
   logic [SETUP_W-1:0]  setup_word;
   logic [7:0]          decv;
   int                  n_errors, tests_run;
   assign decv = {fq, int_ref, ref_buf, temp_en, unsup, scan_en, scan_upd,
                  scan_temp};

   adc_setup_word_and_readout u_dut (
      .REF_CLK(ref_clk), .RST_B(rst_b), .CONVERT_STROBE(convert_strobe), .SCK(sck),
      .DIN(din), .SDO(sdo), .SDO_OE(sdo_oe), .RESULT_VALID(res_valid),
      .RESULT_DATA(res_data), .RESULT_READY(res_ready),
      .SETUP_WORD(setup_word), .FILTER_QUARTER_BW(fq), .INT_REF_EN(int_ref),
      .REF_BUF_EN(ref_buf), .TEMP_SENSOR_EN(temp_en),
      .REF_CODE_UNSUPPORTED(unsup), .SCAN_EN(scan_en),
      .SCAN_UPDATE_EN(scan_upd), .SCAN_TEMP_EN(scan_temp),
      .CONVERTING(converting), .EOC_PULSE(eoc), .BUSY_IND_DISABLE(busy_dis));
   host_ctrl_model u_host (.strobe(convert_strobe), .sck(sck), .din(din), .sdo(sdo),
                           .sdo_oe(sdo_oe));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] dec(input logic [13:0] w);
      logic [2:0] r;
      r   = w[5:3];
      dec = {~w[6], r == 3'h1, r == 3'h1 || r == 3'h3 || r == 3'h7,
             r == 3'h2 || r == 3'h3, r == 3'h4 || r == 3'h5,
             w[2:1] != 2'h0, w[2:1] == 2'h1, w[2:1] == 2'h2};
   endfunction

   function automatic logic [15:0] dword(input int k);
      dword = {4'(k), 12'h5a3} ^ 16'h8001;
   endfunction

   task automatic chk(input string what, input logic [29:0] e,
                      input logic [29:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic push(input logic [15:0] d);
      @(negedge ref_clk);
      res_valid = 1'b1;
      res_data  = d;
      while (res_ready !== 1'b1) @(negedge ref_clk);
      @(negedge ref_clk);
      res_valid = 1'b0;
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      #300000;
      n_errors++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin : main
      logic [29:0] rd;
      logic [13:0] w, wl, wr;
      logic [2:0]  codes [8];
      codes = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h0, 3'h4, 3'h5};
      n_errors  = 0;
      tests_run = 0;
      rst_b     = 1'b0;
      res_valid = 1'b0;
      res_data  = '0;
      repeat (10) @(posedge ref_clk);
      @(negedge ref_clk) rst_b = 1'b1;
      chk("setup reset", 30'(SETUP_DEFAULT), 30'(setup_word));
      chk("decode reset", 30'(dec(SETUP_DEFAULT)), 30'(decv));
      chk("sdo enable reset", 30'h0, 30'(sdo_oe));
      $display("Test reset done");
      for (int k = 0; k < 8; k++) push(dword(k));
      @(negedge ref_clk);
      res_valid = 1'b1;
      res_data  = 16'hdead;
      repeat (3) @(negedge ref_clk);
      chk("fifo full", 30'h0, 30'(res_ready));
      res_valid = 1'b0;
      u_host.convert(1'b1);
      chk("busy disable", 30'h1, 30'(busy_dis));
      for (int k = 0; k < 8; k++) begin
         w = {1'b1, 6'h2a, 1'(k), codes[k], 2'(k), 1'b1};
         u_host.frame(w, 16, rd);
         chk("result", 30'(dword(k)), 30'(rd[29:14]));
         chk("sdo release 16", 30'h0, 30'(sdo_oe));
         u_host.convert(1'b1);
         chk("setup applied", 30'(w), 30'(setup_word));
         chk("decode", 30'(dec(w)), 30'(decv));
      end
      $display("Test fifo and decode done");
      wl = w;
      push(16'h1e01);
      u_host.frame(14'h0aaa, 16, rd);
      chk("reused result", 30'(dword(7)), 30'(rd[29:14]));
      u_host.convert(1'b1);
      chk("setup not gated", 30'(wl), 30'(setup_word));
      push(16'h2e02);
      u_host.frame(14'h3ff0, 10, rd);
      u_host.convert(1'b1);
      chk("setup partial", 30'(wl), 30'(setup_word));
      $display("Test discard done");
      wr = 14'h2a12;
      u_host.frame(wr, 16, rd);
      chk("newest result", 30'(16'h2e02), 30'(rd[29:14]));
      u_host.convert(1'b1);
      chk("setup readback on", 30'(wr), 30'(setup_word));
      u_host.convert(1'b1);
      u_host.frame(14'h3fff, 30, rd);
      chk("readback", {16'h2e02, wr}, rd);
      chk("sdo release 30", 30'h0, 30'(sdo_oe));
      $display("Test readback done");
      u_host.convert(1'b0);
      chk("busy enable", 30'h0, 30'(busy_dis));
      chk("setup all ones", 30'h3fff, 30'(setup_word));
      $display("Test strobe low done");
      print_verdict();
   end
endmodule // adc_setup_word_and_readout_test

bind adc_setup_word_and_readout adc_setup_word_and_readout_properties u_props (
   .REF_CLK(REF_CLK), .RST_B(RST_B), .CONVERT_STROBE(CONVERT_STROBE),
   .SCK(SCK), .SDO(SDO), .SDO_OE(SDO_OE), .SETUP_WORD(SETUP_WORD),
   .FILTER_QUARTER_BW(FILTER_QUARTER_BW), .INT_REF_EN(INT_REF_EN),
   .REF_CODE_UNSUPPORTED(REF_CODE_UNSUPPORTED), .SCAN_EN(SCAN_EN),
   .CONVERTING(CONVERTING), .EOC_PULSE(EOC_PULSE),
   .BUSY_IND_DISABLE(BUSY_IND_DISABLE));
